// ==== ioexp_event_defs.svh ====
// register offsets, field positions, reset values for the expander address
// and general event control bank; assumes a 32-bit apb slave with byte addresses
`ifndef IOEXP_EVENT_DEFS_SVH
`define IOEXP_EVENT_DEFS_SVH
`define ADDR_GROUP_ONE 12'h438
`define ADDR_GROUP_TWO 12'h43C
`define ADDR_EVENT_CTL 12'h450
`define ADDR_EVENT_STS 12'h454
`define ADDR_IRQ_STS 12'h460
`define ADDR_IRQ_EN 12'h464
`define ADDR_IRQ_CLR 12'h468
`define ADDR_SEL_CTL 12'h46C
`define GROUP_TWO_MASK 32'h00FEFEFE
`define GROUP_ONE_MASK 32'hFEFEFEFE
`define EVENT_CTL_MASK 32'h0000003F
`define EVENT_CTL_RESET 32'h00000000
`define ADDR_RESET 7'h00
`define NUM_EXPANDERS 7
`define FIRST_EXPANDER 4
`define NUM_PORTS 5
`define SEL_DONE_BIT 31
`endif

// ==== ioexp_event_pkg.sv ====
// types for the expander address and general event control bank
// assumes the defines header is compiled alongside
package ioexp_event_pkg;
   typedef logic [6:0] bus_addr_type;
   typedef enum logic [1:0] {st_idle, st_wait_init} seq_state_type;
endpackage : ioexp_event_pkg

// ==== ioexp_addr_and_event_ctl.sv ====
// expander address registers, general event control/status, apb slave
// assumes synchronous inputs on pclk; smbus master and gpio mux lie outside
//
// Contract
// - group one holds expander 4..7 addresses at 7:1,15:9,23:17,31:25
// - group two holds expander 8..10 addresses; bits 31:24 read zero
// - address fields reset zero, writable only when unlocked, sticky
// - smbus master uses stored address for the addressed expander
// - bit 0 sets event output polarity: 0 active low, 1 active high
// - port 1 enable diverts its notifications to the event output
// - enables 2..5 do the same for ports 2..5, reset zero, sticky
// - event output for ports 1..5 is alternate function of gpio 7
// - address write to selected expander sets w1c done after init completes
// - status bit set while port asserts event, never when enable clear
// - pin driven with event output only when alternate function chosen
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "ioexp_event_defs.svh"
module ioexp_addr_and_event_ctl
   import ioexp_event_pkg::*;
#(
   parameter int NUM_PORTS = `NUM_PORTS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sticky_rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic write_lock,
   input wire logic [3:0] smbus_target_sel,
   output logic [6:0] smbus_target_addr,
   input wire logic init_done,
   input wire logic [NUM_PORTS:1] port_event,
   output logic [NUM_PORTS:1] port_native_enable,
   input wire logic gpio7_alt_sel,
   output logic gpio7_out,
   output logic gpio7_oe,
   output logic irq
);
   initial begin
      if (NUM_PORTS < 1 || NUM_PORTS > `NUM_PORTS) $error("NUM_PORTS unsupported");
   end

   // state in two structs; sticky one reset only by sticky_rst_n
   typedef struct packed {
      bus_addr_type [`NUM_EXPANDERS-1:0] exp_addr;
      logic polarity;
      logic [NUM_PORTS:1] redirect;
      logic [3:0] sel;
      logic done;
   } sticky_type;
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [6:0] tgt;
      logic [NUM_PORTS:1] native;
      logic [NUM_PORTS:1] sts;
      logic [1:0] irq_sts;
      logic [1:0] irq_en;
      logic gpio_out;
      logic gpio_oe;
      logic irq;
      seq_state_type seq;
   } state_type;

   sticky_type sk, next_sk;
   state_type st, next_st;

   // index of expander for a register word and field slot
   function automatic int exp_index(input logic [11:0] a, input int slot);
      exp_index = (a == `ADDR_GROUP_ONE) ? slot : 4 + slot;
   endfunction : exp_index

   logic wr_acc, rd_acc, any_evt, evt_level;
   always_comb begin
      wr_acc = psel && penable && pwrite && !st.ready;
      rd_acc = psel && !penable && !pwrite;
   end

   always_comb begin
      next_sk = sk;
      next_st = st;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      any_evt = 1'b0;
      evt_level = 1'b0;
      // apb writes; address fields only while unlocked
      if (wr_acc) begin
         next_st.ready = 1'b1;
         unique case (paddr)
            `ADDR_GROUP_ONE, `ADDR_GROUP_TWO: begin
               if (!write_lock) begin
                  for (int s = 0; s < 4; s++) begin
                     if (exp_index(paddr, s) < `NUM_EXPANDERS) begin
                        next_sk.exp_addr[exp_index(paddr, s)] = pwdata[8*s+1 +: 7];
                        // write to selected expander arms the init sequence
                        if (4'(exp_index(paddr, s) + `FIRST_EXPANDER) == sk.sel) begin
                           next_st.seq = st_wait_init;
                        end
                     end
                  end
               end
            end
            `ADDR_EVENT_CTL: begin
               next_sk.polarity = pwdata[0];
               next_sk.redirect = pwdata[NUM_PORTS:1];
            end
            `ADDR_SEL_CTL: begin
               next_sk.sel = pwdata[29:26];
               if (pwdata[`SEL_DONE_BIT]) next_sk.done = 1'b0;
            end
            `ADDR_IRQ_EN: next_st.irq_en = pwdata[1:0];
            `ADDR_IRQ_CLR: next_st.irq_sts = st.irq_sts & ~pwdata[1:0];
            `ADDR_EVENT_STS, `ADDR_IRQ_STS: ;
            default: next_st.err = 1'b1;
         endcase
      end else if (psel && penable && !st.ready) begin
         next_st.ready = 1'b1;
         next_st.err = !(paddr inside {`ADDR_GROUP_ONE, `ADDR_GROUP_TWO, `ADDR_EVENT_CTL,
            `ADDR_EVENT_STS, `ADDR_IRQ_STS, `ADDR_IRQ_EN, `ADDR_SEL_CTL});
      end
      // read data captured in setup so it stands through access
      if (rd_acc) begin
         unique case (paddr)
            `ADDR_GROUP_ONE, `ADDR_GROUP_TWO: begin
               next_st.rdata = 32'h0;
               for (int s = 0; s < 4; s++) begin
                  if (exp_index(paddr, s) < `NUM_EXPANDERS)
                     next_st.rdata[8*s+1 +: 7] = sk.exp_addr[exp_index(paddr, s)];
               end
            end
            `ADDR_EVENT_CTL: next_st.rdata = 32'({sk.redirect, sk.polarity});
            `ADDR_EVENT_STS: next_st.rdata = 32'({st.sts, 1'b0});
            `ADDR_IRQ_STS: next_st.rdata = 32'(st.irq_sts);
            `ADDR_IRQ_EN: next_st.rdata = 32'(st.irq_en);
            `ADDR_SEL_CTL: next_st.rdata = {sk.done, 1'b0, sk.sel, 26'h0};
            default: next_st.rdata = 32'h0;
         endcase
      end
      // init sequence completion raises done; set beats clear
      unique case (st.seq)
         st_idle: ;
         st_wait_init: begin
            if (init_done) begin
               next_sk.done = 1'b1;
               next_st.seq = st_idle;
               any_evt = 1'b1;
            end
         end
         default: next_st.seq = st_idle;
      endcase
      // smbus target address for the selected expander
      next_st.tgt = (smbus_target_sel >= 4'(`FIRST_EXPANDER) &&
         smbus_target_sel < 4'(`FIRST_EXPANDER + `NUM_EXPANDERS)) ?
         sk.exp_addr[smbus_target_sel - 4'(`FIRST_EXPANDER)] : `ADDR_RESET;
      // redirected ports lose native notifications; status gated by enable
      next_st.native = ~sk.redirect;
      // gate with the enable being written now, so a cleared enable never leaves
      // its status bit standing for one more cycle
      next_st.sts = port_event & next_sk.redirect;
      evt_level = |next_st.sts;
      next_st.gpio_out = sk.polarity ? evt_level : !evt_level;
      next_st.gpio_oe = gpio7_alt_sel;
      // sticky interrupt bits: 0 done, 1 event rising
      if (any_evt) next_st.irq_sts[0] = 1'b1;
      if (evt_level && !(|st.sts)) next_st.irq_sts[1] = 1'b1;
      next_st.irq = |(next_st.irq_sts & next_st.irq_en);
   end

   // sticky fields survive the ordinary reset
   always_ff @(posedge pclk or negedge sticky_rst_n) begin
      if (!sticky_rst_n) sk <= '0;
      else sk <= next_sk;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.seq <= st_idle;
         st.gpio_out <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      prdata = st.rdata;
      pready = st.ready;
      pslverr = st.err;
      smbus_target_addr = st.tgt;
      port_native_enable = st.native;
      gpio7_out = st.gpio_out;
      gpio7_oe = st.gpio_oe;
      irq = st.irq;
   end

   a_status_gated: assert property (@(posedge pclk) disable iff (!presetn)
      (st.sts & ~sk.redirect) == '0) else $error("status set without enable");
   a_pin_alt_only: assert property (@(posedge pclk) disable iff (!presetn)
      !gpio7_alt_sel |=> !gpio7_oe) else $error("pin driven outside alt function");
   a_polarity_out: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (gpio7_out == ($past(sk.polarity) ? |st.sts : !(|st.sts))))
      else $error("event output polarity wrong");
   a_native_off: assert property (@(posedge pclk) disable iff (!presetn)
      $past(sk.redirect[1]) |-> !port_native_enable[1]) else $error("port1 not diverted");
   a_target_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (smbus_target_sel == 4'h4 && $stable(sk.exp_addr[0])) |=> smbus_target_addr ==
      $past(sk.exp_addr[0])) else $error("wrong smbus target");
   a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (write_lock && !$past(rd_acc)) |=> $stable(sk.exp_addr)) else $error("locked write took");
   a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
      (st.seq == st_wait_init && init_done) |=> sk.done) else $error("done not set");
   a_group_two_top: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == `ADDR_GROUP_TWO) |=> prdata[31:24] == 8'h00)
      else $error("group two top bits nonzero");
   a_enable_store: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `ADDR_EVENT_CTL) |=> sk.redirect == $past(pwdata[NUM_PORTS:1]))
      else $error("enable write lost");
endmodule : ioexp_addr_and_event_ctl

// ==== ioexp_partner_model.sv ====
// stand-in for the expander chips on the master smbus
// assumes one pclk; an address change starts a short init sequence
`timescale 1ns/1ps
module ioexp_partner_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [6:0] smbus_target_addr,
   output logic init_done
);
   logic [6:0] last_addr;
   logic [2:0] wait_cnt;
   // new target address: init finishes four cycles later, one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr <= 7'h00;
         wait_cnt <= 3'h0;
         init_done <= 1'b0;
      end else begin
         init_done <= (wait_cnt == 3'h1);
         if (smbus_target_addr != last_addr) wait_cnt <= 3'h4;
         else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
         last_addr <= smbus_target_addr;
      end
   end
endmodule : ioexp_partner_model

// ==== ioexp_addr_and_event_ctl_bench.sv ====
// self-checking bench for the expander address and event control bank
// assumes the design, its defines header and the partner model are compiled
`timescale 1ns/1ps
`include "ioexp_event_defs.svh"
module ioexp_addr_and_event_ctl_bench;
   logic pclk = 0, presetn = 0, sticky_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, err, write_lock = 0, init_done, gpio7_alt_sel = 0, gpio7_out;
   logic gpio7_oe, irq;
   logic [3:0] smbus_target_sel = 4'h4;
   logic [6:0] smbus_target_addr;
   logic [5:1] port_event = 5'h00, port_native_enable;
   int fails = 0, checks_done = 0;
   always #12.5 pclk = ~pclk;
   ioexp_addr_and_event_ctl u_ioexp_addr_and_event_ctl (.pclk(pclk), .presetn(presetn),
      .sticky_rst_n(sticky_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_lock(write_lock), .smbus_target_sel(smbus_target_sel),
      .smbus_target_addr(smbus_target_addr), .init_done(init_done), .port_event(port_event),
      .port_native_enable(port_native_enable), .gpio7_alt_sel(gpio7_alt_sel),
      .gpio7_out(gpio7_out), .gpio7_oe(gpio7_oe), .irq(irq));
   ioexp_partner_model u_ioexp_partner_model (.pclk(pclk), .presetn(presetn),
      .smbus_target_addr(smbus_target_addr), .init_done(init_done));
   // one apb transfer, request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // let event inputs settle through the registered outputs
   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   task test_reset_and_fields;
      apb(0, `ADDR_GROUP_ONE, 0); chk(r, 32'h0);
      apb(0, `ADDR_EVENT_CTL, 0); chk(r, 32'h0);
      apb(1, `ADDR_SEL_CTL, 32'h10000000); // select expander 4 for done tracking
      apb(1, `ADDR_GROUP_ONE, 32'h09070503);
      apb(1, `ADDR_GROUP_TWO, 32'hFF0F0D0B);
      apb(0, `ADDR_GROUP_ONE, 0); chk(r, 32'h08060402);
      apb(0, `ADDR_GROUP_TWO, 0); chk(r, 32'h000E0C0A);
      write_lock <= 1;
      apb(1, `ADDR_GROUP_ONE, 32'h0);
      apb(0, `ADDR_GROUP_ONE, 0); chk(r, 32'h08060402);
      write_lock <= 0;
      apb(0, 12'h7F0, 0); chk({31'h0, err}, 32'h1); // unmapped address refused
   endtask : test_reset_and_fields
   task test_targets_and_done;
      for (int n = 4; n <= 10; n++) begin
         smbus_target_sel <= 4'(n);
         settle();
         chk({25'h0, smbus_target_addr}, 32'(n - 3));
      end
      apb(0, `ADDR_SEL_CTL, 0); chk(r, 32'h90000000);
      apb(1, `ADDR_IRQ_EN, 32'h1);
      #1; chk({31'h0, irq}, 32'h1);
      apb(1, `ADDR_IRQ_CLR, 32'h1);
      apb(1, `ADDR_SEL_CTL, 32'h90000000);
      apb(0, `ADDR_SEL_CTL, 0); chk(r, 32'h10000000);
      #1; chk({31'h0, irq}, 32'h0);
   endtask : test_targets_and_done
   task test_events;
      apb(1, `ADDR_IRQ_EN, 32'h0);
      apb(1, `ADDR_EVENT_CTL, 32'h3); // active high, port 1 redirected
      gpio7_alt_sel <= 1; port_event <= 5'h01;
      settle();
      chk({gpio7_oe, gpio7_out, port_native_enable}, {2'b11, 5'h1E});
      apb(0, `ADDR_EVENT_STS, 0); chk(r, 32'h2);
      port_event <= 5'h02;
      settle();
      chk({gpio7_out}, 1'b0);
      apb(0, `ADDR_EVENT_STS, 0); chk(r, 32'h0);
      apb(1, `ADDR_EVENT_CTL, 32'h3E); // active low, ports 1..5 redirected
      port_event <= 5'h10;
      settle();
      chk({gpio7_out, port_native_enable}, 6'h00);
      gpio7_alt_sel <= 0;
      settle();
      chk({gpio7_oe}, 1'b0);
      // enables cleared while port 5 still raises its event
      apb(1, `ADDR_EVENT_CTL, 32'h1);
      settle();
      apb(0, `ADDR_EVENT_STS, 0); chk(r, 32'h0);
      chk({gpio7_out, port_native_enable}, 6'h1F);
   endtask : test_events
   // watchdog: the whole run needs well under 4000 cycles
   initial begin
      #100us;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1; sticky_rst_n <= 1;
      test_reset_and_fields();
      test_targets_and_done();
      test_events();
      report_and_stop();
   end
endmodule : ioexp_addr_and_event_ctl_bench
